// file: core/dperr_core.sv
// Purpose: error classification, logging and response for datapath faults
// Assumes: event inputs are pulses on pclk; pins are asynchronous
// Notes: status/log registers reset only by pwr_on_rst_n
`default_nettype none

module dperr_core
    import dperr_pkg::*;
#(
    parameter int HOLD_CYC = BUS_INIT_SIGNAL_HOLD_CYC
) (
    // clock and resets
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pwr_on_rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // internal fault reports
    input wire dperr_dp_evt_s dp_evt,
    input wire dperr_ac_evt_s ac_evt,
    input wire dperr_info_s info,
    // asynchronous fault pins
    input wire logic bridge_fatal_input_n,
    input wire logic mem_chip_err_n,
    input wire logic bus_error_signal_n,
    // responses
    output logic bus_init_signal_n,
    output logic bridge_fatal_out_n,
    output logic irq,
    output dperr_act_s act
);

    if (HOLD_CYC < 1 || HOLD_CYC > 255) begin : g_chk
        $error("HOLD_CYC must lie in 1..255");
    end

    //------------------------------------------------------------------
    // pin synchronisers and filters
    //------------------------------------------------------------------
    logic [2:0] pin_raw;
    logic [2:0] pin_flt;
    logic [2:0] pin_flt_d;
    logic [2:0] pin_evt;

    assign pin_raw = {bus_error_signal_n, mem_chip_err_n,
        bridge_fatal_input_n};

    for (genvar i = 0; i < 3; i++) begin : g_sync
        logic [SYNC_STAGES-1:0] s;
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                s <= '1;
                pin_flt[i] <= 1'b1;
                pin_flt_d[i] <= 1'b1;
            end else begin
                s <= {s[SYNC_STAGES-2:0], pin_raw[i]};
                if (s[1] == s[2]) begin
                    pin_flt[i] <= s[2];
                end
                pin_flt_d[i] <= pin_flt[i];
            end
        end
        assign pin_evt[i] = pin_flt_d[i] & ~pin_flt[i];
    end

    logic bf_evt;
    logic mem_evt;
    logic bus_error_signal_evt;
    assign bf_evt = pin_evt[0];
    assign mem_evt = pin_evt[1];
    assign bus_error_signal_evt = pin_evt[2];

    //------------------------------------------------------------------
    // apb access
    //------------------------------------------------------------------
    logic [CTL_W-1:0] ctrl;
    logic [AF_W-1:0] mask;
    logic [AF_W-1:0] ac_first;
    logic [AF_W-1:0] ac_next;
    logic [DF_W-1:0] dp_first;
    logic [ADDR_W-1:0] addr_log;
    logic [TID_W-1:0] sb_tid;
    logic [TID_W-1:0] db_tid;
    logic [TID_W-1:0] fb_tid;
    logic [CMD_W-1:0] cmd_log;
    logic wr_en;
    logic [AF_W-1:0] clr_first;
    logic [AF_W-1:0] clr_next;
    logic [DF_W-1:0] clr_dp;

    assign wr_en = psel & penable & pready & pwrite;
    assign clr_first = (wr_en && paddr == OFF_AC_FIRST) ?
        pwdata[AF_W-1:0] : '0;
    assign clr_next = (wr_en && paddr == OFF_AC_NEXT) ?
        pwdata[AF_W-1:0] : '0;
    assign clr_dp = (wr_en && paddr == OFF_DP_FIRST) ?
        pwdata[DF_W-1:0] : '0;

    logic [31:0] next_rdata;
    logic next_err;
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_err = 1'b0;
        unique case (paddr)
            OFF_CTRL: next_rdata[CTL_W-1:0] = ctrl;
            OFF_AC_FIRST: next_rdata[AF_W-1:0] = ac_first;
            OFF_AC_NEXT: next_rdata[AF_W-1:0] = ac_next;
            OFF_DP_FIRST: next_rdata[DF_W-1:0] = dp_first;
            OFF_MASK: next_rdata[AF_W-1:0] = mask;
            OFF_ADDR_LOG: next_rdata[ADDR_W-1:0] = addr_log;
            OFF_SB_TID: next_rdata[TID_W-1:0] = sb_tid;
            OFF_DB_TID: next_rdata[TID_W-1:0] = db_tid;
            OFF_FB_TID: next_rdata[TID_W-1:0] = fb_tid;
            OFF_CMD_LOG: next_rdata[CMD_W-1:0] = cmd_log;
            default: next_err = 1'b1;
        endcase
    end

    // answer in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & next_err;
            if (psel && !penable && !pwrite) begin
                prdata <= next_rdata;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RST;
            mask <= MASK_RST;
        end else if (wr_en) begin
            if (paddr == OFF_CTRL) begin
                ctrl <= pwdata[CTL_W-1:0];
            end
            if (paddr == OFF_MASK) begin
                mask <= pwdata[AF_W-1:0];
            end
        end
    end

    //------------------------------------------------------------------
    // classification
    //------------------------------------------------------------------
    logic held;
    logic [AF_W-1:0] aev;
    logic [AF_W-1:0] keep_corrected_memory_error_flag;
    logic fatal;
    logic par_grp;

    assign keep_corrected_memory_error_flag = AF_W'(1) << AF_CORRECTED_MEMORY_ERROR_FLAG;
    assign held = |(ac_first & ~keep_corrected_memory_error_flag); // R17 R18
    assign par_grp = ac_evt.addr_par | ac_evt.req_par | ac_evt.asz_bad;

    always_comb begin
        aev = '0;
        aev[AF_SNE] = dp_evt.sys_1x | dp_evt.sys_2x | dp_evt.mem_2x
            | dp_evt.data_par | dp_evt.be_par | dp_evt.buf_par
            | (dp_evt.mem_1x & ac_first[AF_CORRECTED_MEMORY_ERROR_FLAG]); // R3 R4 R5 R6 R7 R16 R18
        aev[AF_CORRECTED_MEMORY_ERROR_FLAG] = dp_evt.mem_1x & ~ac_first[AF_CORRECTED_MEMORY_ERROR_FLAG]; // R3 R18
        aev[AF_SFE] = dp_evt.cmd_par | dp_evt.rsp_err | dp_evt.id_par
            | dp_evt.rx_len | dp_evt.cfg_par | dp_evt.len_proto
            | dp_evt.wr_proto | dp_evt.data_ready_signal_proto; // R8 R12
        aev[AF_FRE] = ac_evt.false_retire; // R9
        aev[AF_RPE] = ac_evt.retire_par; // R9
        aev[AF_IPE] = ac_evt.pdb_id_par; // R9
        aev[AF_SRU] = ac_evt.store_undf; // R9
        aev[AF_AE] = ac_evt.addr_par; // R10
        aev[AF_RQE] = ac_evt.req_par; // R10
        aev[AF_ASE] = ac_evt.asz_bad; // R10
        aev[AF_IHS] = ac_evt.modified_hit_response_exp; // R11
        aev[AF_TE] = ac_evt.above_tom; // R11
        aev[AF_BER] = bus_error_signal_evt; // R13
        aev[AF_IUE] = ac_evt.ioq_err; // R14
        aev[AF_XBE] = bf_evt; // R14
        aev[AF_LTE] = ac_evt.lock_nores; // R14
        aev[AF_RCE] = ac_evt.res_cnt; // R14
        aev[AF_MXE] = mem_evt; // R15
    end

    // bus error bit left out: it is fatal only through the conversion
    assign fatal = (|aev[AF_MXE:AF_IUE])
        | (|aev[AF_TE:AF_IHS])
        | (|aev[AF_SRU:AF_SFE])
        | (par_grp & ctrl[CTL_PAR_FLAG])
        | (bus_error_signal_evt & ctrl[CTL_BUS_ERROR_SIGNAL_CONV]); // R8 R9 R10 R11 R12 R13 R14 R15

    //------------------------------------------------------------------
    // sticky status, kept across presetn
    //------------------------------------------------------------------
    always_ff @(posedge pclk or negedge pwr_on_rst_n) begin // R1
        if (!pwr_on_rst_n) begin
            ac_first <= '0;
            ac_next <= '0;
            dp_first <= '0;
        end else begin
            ac_first <= (ac_first & ~clr_first) | (held ? '0 : aev); // R17 R19
            ac_next <= (ac_next & ~clr_next) | (held ? aev : '0); // R17 R18
            dp_first <= (dp_first & ~clr_dp) | DF_W'(dp_evt); // R19
        end
    end

    // address and command logs capture only the fault that took the first flag; id logs the first of each 1x and 2x event, one per cycle with mem_2x first
    always_ff @(posedge pclk or negedge pwr_on_rst_n) begin // R1
        if (!pwr_on_rst_n) begin
            addr_log <= '0;
            sb_tid <= '0;
            db_tid <= '0;
            fb_tid <= '0;
            cmd_log <= '0;
        end else begin
            if (par_grp && !held) begin
                addr_log <= info.addr; // R10 R19
            end
            if (mem_evt && !held) begin
                cmd_log <= info.mem_cmd; // R15 R19
            end
            if (dp_evt.mem_2x && !dp_first[3]) begin
                db_tid <= info.txn_id; // R5
            end else if ((dp_evt.sys_1x && !dp_first[0])
                    || (dp_evt.sys_2x && !dp_first[1])) begin
                fb_tid <= info.txn_id; // R19
            end else if (dp_evt.mem_1x && !dp_first[2]) begin
                sb_tid <= info.txn_id; // R19
            end
        end
    end

    //------------------------------------------------------------------
    // responses
    //------------------------------------------------------------------
    logic [7:0] hold_cnt;
    logic bus_init_signal_on;
    assign bus_init_signal_on = fatal | (hold_cnt != 8'h00);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_cnt <= 8'h00;
            bus_init_signal_n <= 1'b1;
            bridge_fatal_out_n <= 1'b1;
        end else begin
            if (fatal) begin
                hold_cnt <= 8'(HOLD_CYC - 1);
            end else if (hold_cnt != 8'h00) begin
                hold_cnt <= hold_cnt - 8'h01;
            end
            bus_init_signal_n <= ~(bus_init_signal_on & ctrl[CTL_BUS_INIT_SIGNAL_EN]); // R2
            bridge_fatal_out_n <= ~(bus_init_signal_on & ctrl[CTL_BRIDGE_EN]); // R2
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= ctrl[CTL_IRQ_EN] & ((|(ac_first & mask))
                | dp_first[14]); // R2 R3 R16
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act <= '0;
        end else begin
            act.fwd_corrected <= dp_evt.sys_1x | dp_evt.mem_1x; // R3
            act.poison_mem_write <= dp_evt.sys_2x; // R4
            act.poison_bus_fwd <= dp_evt.mem_2x; // R5
            act.poison_chunk <= dp_evt.data_par & ~dp_evt.be_par; // R6
            act.poison_line <= dp_evt.be_par; // R7
        end
    end

    //------------------------------------------------------------------
    // assertions
    //------------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_bus_init_signal_held;
        !bus_init_signal_n [*2];
    endsequence

    property p_bus_init_signal_gate;
        !ctrl[CTL_BUS_INIT_SIGNAL_EN] |=> bus_init_signal_n;
    endproperty
    a_bus_init_signal_gate: assert property (p_bus_init_signal_gate) // R2
        else $error("bus init driven while disabled");

    property p_irq_gate;
        !ctrl[CTL_IRQ_EN] |=> !irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate) // R2
        else $error("interrupt driven while disabled");

    property p_link_fatal;
        dp_evt.cmd_par && ctrl[CTL_BUS_INIT_SIGNAL_EN] && !wr_en
            |=> s_bus_init_signal_held;
    endproperty
    a_link_fatal: assert property (p_link_fatal) // R8
        else $error("link fault gave no bus init");

    property p_retire;
        ac_evt.false_retire && ctrl[CTL_BUS_INIT_SIGNAL_EN] && !wr_en
            |=> !bus_init_signal_n;
    endproperty
    a_retire: assert property (p_retire) // R9
        else $error("false retirement gave no bus init");

    property p_par_cond;
        ac_evt.addr_par && ctrl[CTL_PAR_FLAG] && ctrl[CTL_BUS_INIT_SIGNAL_EN]
            && !wr_en |=> !bus_init_signal_n;
    endproperty
    a_par_cond: assert property (p_par_cond) // R10
        else $error("enabled parity fault gave no bus init");

    property p_first_next;
        held && aev[AF_RPE] |=> ac_next[AF_RPE];
    endproperty
    a_first_next: assert property (p_first_next) // R17
        else $error("second error missed next-error status");

    property p_corrected_memory_error_flag_first;
        dp_evt.mem_1x && !ac_first[AF_CORRECTED_MEMORY_ERROR_FLAG] && !held
            |=> ac_first[AF_CORRECTED_MEMORY_ERROR_FLAG];
    endproperty
    a_corrected_memory_error_flag_first: assert property (p_corrected_memory_error_flag_first) // R18
        else $error("first 1x did not set corrected flag");

    property p_line_poison;
        dp_evt.be_par |=> act.poison_line && !act.poison_chunk;
    endproperty
    a_line_poison: assert property (p_line_poison) // R7
        else $error("byte-enable parity did not poison line");

    property p_buf_irq;
        dp_evt.buf_par && ctrl[CTL_IRQ_EN] && !wr_en |=> ##1 irq;
    endproperty
    a_buf_irq: assert property (p_buf_irq) // R16
        else $error("buffer parity gave no interrupt");

    property p_hold;
        fatal && ctrl[CTL_BUS_INIT_SIGNAL_EN]
            |=> !bus_init_signal_n && hold_cnt == 8'(HOLD_CYC - 1);
    endproperty
    a_hold: assert property (p_hold) // R14
        else $error("bus init hold counter lost");

    property p_queue_fatal;
        ac_evt.ioq_err && ctrl[CTL_BUS_INIT_SIGNAL_EN] |=> !bus_init_signal_n;
    endproperty
    a_queue_fatal: assert property (p_queue_fatal) // R14
        else $error("queue fault gave no bus init");

    property p_sne_flag;
        dp_evt.sys_2x && !held |=> ac_first[AF_SNE];
    endproperty
    a_sne_flag: assert property (p_sne_flag) // R4
        else $error("bus write 2x did not set noncritical flag");

endmodule : dperr_core

`default_nettype wire

// file: core/dperr_pkg.sv
// Purpose: constants and carriers for the datapath error response block
// Assumes: one core clock, registers reached over APB, 32-bit data
// Notes: status and log words live on a separate power-on reset
//----------------------------------------------------------------------
// Overview of operation
// R1 - captured status survives reset, readable by software
// R2 - each fatal or interrupt output has driver enable
// R3 - memory/bus 1x: correct, forward, flag, masked interrupt
// R4 - bus write 2x: poison memory write, noncritical flag
// R5 - memory read 2x: poison forward, log transaction id
// R6 - data parity: poison only failing chunk
// R7 - byte-enable parity: poison whole line
// R8 - datapath link faults: bus-init, fatal datapath flag
// R9 - retirement faults: unconditional bus-init, no log
// R10 - address/request/size faults: bus-init if enabled, log
// R11 - modified hit or above memory top: bus-init
// R12 - length/ready/write protocol faults: bus-init, fatal flag
// R13 - bus error converts to bus-init when enabled
// R14 - queue, lock, counter, bridge fatal: bus-init
// R15 - memory chip command parity: bus-init, log command
// R16 - buffer parity: unconditional interrupt, noncritical flag
// R17 - first-error only when empty, else next-error (code counts a lone corrected flag as empty)
// R18 - repeated 1x: corrected flag, then noncritical, then next
// R19 - flags sticky until cleared, logs only first fault
//----------------------------------------------------------------------
`default_nettype none

package dperr_pkg;

    // register offsets
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_AC_FIRST = 12'h004;
    localparam logic [11:0] OFF_AC_NEXT = 12'h008;
    localparam logic [11:0] OFF_DP_FIRST = 12'h00C;
    localparam logic [11:0] OFF_MASK = 12'h010;
    localparam logic [11:0] OFF_ADDR_LOG = 12'h014;
    localparam logic [11:0] OFF_SB_TID = 12'h018;
    localparam logic [11:0] OFF_DB_TID = 12'h01C;
    localparam logic [11:0] OFF_FB_TID = 12'h020;
    localparam logic [11:0] OFF_CMD_LOG = 12'h024;

    // control bits
    localparam int CTL_W = 5;
    localparam int CTL_BUS_INIT_SIGNAL_EN = 0;
    localparam int CTL_BRIDGE_EN = 1;
    localparam int CTL_IRQ_EN = 2;
    localparam int CTL_PAR_FLAG = 3;
    localparam int CTL_BUS_ERROR_SIGNAL_CONV = 4;
    localparam logic [CTL_W-1:0] CTRL_RST = 5'h07;

    // address controller flag positions
    localparam int AF_W = 18;
    localparam int AF_SNE = 0;
    localparam int AF_CORRECTED_MEMORY_ERROR_FLAG = 1;
    localparam int AF_SFE = 2;
    localparam int AF_FRE = 3;
    localparam int AF_RPE = 4;
    localparam int AF_IPE = 5;
    localparam int AF_SRU = 6;
    localparam int AF_AE = 7;
    localparam int AF_RQE = 8;
    localparam int AF_ASE = 9;
    localparam int AF_IHS = 10;
    localparam int AF_TE = 11;
    localparam int AF_BER = 12;
    localparam int AF_IUE = 13;
    localparam int AF_XBE = 14;
    localparam int AF_LTE = 15;
    localparam int AF_RCE = 16;
    localparam int AF_MXE = 17;
    localparam logic [AF_W-1:0] MASK_RST = 18'h00000;

    localparam int TID_W = 8;
    localparam int ADDR_W = 32;
    localparam int CMD_W = 16;
    localparam int DF_W = 15;

    // bus-init hold time
    localparam int CLK_PERIOD_NS = 4;
    localparam int BUS_INIT_SIGNAL_HOLD_NS = 32;
    localparam int BUS_INIT_SIGNAL_HOLD_CYC = BUS_INIT_SIGNAL_HOLD_NS / CLK_PERIOD_NS;
    localparam int SYNC_STAGES = 3;

    // datapath detected events, one-cycle pulses; bit 0 is sys_1x
    typedef struct packed {
        logic buf_par;
        logic data_ready_signal_proto;
        logic wr_proto;
        logic len_proto;
        logic cfg_par;
        logic be_par;
        logic data_par;
        logic rx_len;
        logic id_par;
        logic rsp_err;
        logic cmd_par;
        logic mem_2x;
        logic mem_1x;
        logic sys_2x;
        logic sys_1x;
    } dperr_dp_evt_s;

    // address controller detected events, one-cycle pulses
    typedef struct packed {
        logic res_cnt;
        logic lock_nores;
        logic ioq_err;
        logic above_tom;
        logic modified_hit_response_exp;
        logic asz_bad;
        logic req_par;
        logic addr_par;
        logic store_undf;
        logic pdb_id_par;
        logic retire_par;
        logic false_retire;
    } dperr_ac_evt_s;

    // data captured alongside the events
    typedef struct packed {
        logic [TID_W-1:0] txn_id;
        logic [ADDR_W-1:0] addr;
        logic [CMD_W-1:0] mem_cmd;
    } dperr_info_s;

    // data path actions, one-cycle pulses
    typedef struct packed {
        logic fwd_corrected;
        logic poison_mem_write;
        logic poison_bus_fwd;
        logic poison_chunk;
        logic poison_line;
    } dperr_act_s;

endpackage : dperr_pkg

`default_nettype wire

// file: tb/dperr_far.sv
// Purpose: far-side model driving the asynchronous fault pins
// Assumes: pins are pulled up, so a released pin reads high
// Notes: each request holds its pin low for four cycles
`default_nettype none

module dperr_far (
    // clock
    input wire logic pclk,
    // requests: 0 bridge fatal, 1 memory chip, 2 bus error
    input wire logic [2:0] fire,
    // fault pins
    output logic bridge_fatal_input_n,
    output logic mem_chip_err_n,
    output logic bus_error_signal_n
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [2:0][2:0] cnt = '0;

    always @(posedge pclk) begin
        for (int i = 0; i < 3; i++) begin
            if (fire[i]) begin
                cnt[i] <= 3'h4;
            end else if (cnt[i] != 3'h0) begin
                cnt[i] <= cnt[i] - 3'h1;
            end
        end
    end

    // released pins return to the pull-up level
    assign bridge_fatal_input_n = (cnt[0] == 3'h0);
    assign mem_chip_err_n = (cnt[1] == 3'h0);
    assign bus_error_signal_n = (cnt[2] == 3'h0);
endmodule : dperr_far

`default_nettype wire

// file: tb/tb.sv
// Purpose: self-checking bench for the datapath error response block
// Assumes: APB master, fault pulses and far-side pins driven here
// Notes: hold time shortened through the HOLD_CYC parameter
`default_nettype none

module tb
    import dperr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    //----------------------------------------------------------------
    // signals
    //----------------------------------------------------------------
    localparam int HOLD = 5;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic pwr_on_rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    dperr_dp_evt_s dp_evt = '0;
    dperr_ac_evt_s ac_evt = '0;
    dperr_info_s info = '{8'hA5, 32'h12345678, 16'hBEEF};
    logic [2:0] fire = '0;
    logic bf_n;
    logic mc_n;
    logic be_n;
    logic bus_init_signal_n;
    logic bridge_fatal_out_n;
    logic irq;
    dperr_act_s act;
    logic [31:0] rd;
    logic serr;
    int bad_count = 0;
    int comparisons = 0;

    always #2 pclk = ~pclk;

    dperr_core #(.HOLD_CYC(HOLD)) u_dut (
        .pclk(pclk), .presetn(presetn), .pwr_on_rst_n(pwr_on_rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dp_evt(dp_evt), .ac_evt(ac_evt), .info(info),
        .bridge_fatal_input_n(bf_n), .mem_chip_err_n(mc_n),
        .bus_error_signal_n(be_n), .bus_init_signal_n(bus_init_signal_n),
        .bridge_fatal_out_n(bridge_fatal_out_n), .irq(irq), .act(act)
    );

    dperr_far u_far (
        .pclk(pclk), .fire(fire), .bridge_fatal_input_n(bf_n),
        .mem_chip_err_n(mc_n), .bus_error_signal_n(be_n)
    );

    //----------------------------------------------------------------
    // shared tasks
    //----------------------------------------------------------------
    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) bad_count++;
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdv(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rdv

    task automatic clr();
        wr(OFF_AC_FIRST, 32'hFFFFFFFF);
        wr(OFF_AC_NEXT, 32'hFFFFFFFF);
        wr(OFF_DP_FIRST, 32'hFFFFFFFF);
    endtask : clr

    task automatic fault(input logic [11:0] ac, input logic [14:0] dp);
        @(posedge pclk);
        ac_evt <= dperr_ac_evt_s'(ac);
        dp_evt <= dperr_dp_evt_s'(dp);
        @(posedge pclk);
        ac_evt <= '0;
        dp_evt <= '0;
    endtask : fault

    // counts bus-init low cycles; bridge output checked once, at the first sample
    task automatic hold_chk(input int exp);
        int n;
        n = 0;
        @(negedge pclk);
        chk({31'h0, bridge_fatal_out_n}, {31'h0, exp == 0});
        while (bus_init_signal_n === 1'b0 && n < 300) begin
            n++;
            @(negedge pclk);
        end
        chk(n, exp);
    endtask : hold_chk

    task automatic fatal_case(input logic [11:0] ac, input logic [14:0] dp,
            input logic [31:0] ef, input logic [31:0] ed);
        clr();
        fault(ac, dp);
        hold_chk(HOLD);
        rdv(OFF_AC_FIRST, ef);
        rdv(OFF_DP_FIRST, ed);
        chk({31'h0, irq}, 32'h1);
    endtask : fatal_case

    task automatic pin_case(input int p, input logic e,
            input logic [31:0] flag);
        logic seen;
        clr();
        @(posedge pclk);
        fire[p] <= 1'b1;
        @(posedge pclk);
        fire <= '0;
        seen = 1'b0;
        for (int n = 0; n < 20; n++) begin
            @(negedge pclk);
            if (bus_init_signal_n === 1'b0) seen = 1'b1;
        end
        chk({31'h0, seen}, {31'h0, e});
        rdv(OFF_AC_FIRST, flag);
    endtask : pin_case

    //----------------------------------------------------------------
    // scenarios
    //----------------------------------------------------------------
    task automatic s_regs();
        rdv(OFF_CTRL, 32'h7);
        rdv(OFF_MASK, 32'h0);
        apb(1'b0, 12'h028, 32'h0);
        chk({31'h0, serr}, 32'h1);
        chk(rd, 32'h0);
        wr(OFF_MASK, 32'hFFFFFFFF);
        rdv(OFF_MASK, 32'h3FFFF);
    endtask : s_regs

    task automatic s_fatal();
        int acb[9] = '{0, 1, 2, 3, 7, 8, 9, 10, 11};
        int acf[9] = '{3, 4, 5, 6, 10, 11, 13, 15, 16};
        int dpb[8] = '{4, 5, 6, 7, 10, 11, 12, 13};
        for (int i = 0; i < 9; i++) begin
            fatal_case(12'h1 << acb[i], 15'h0, 32'h1 << acf[i], 0);
        end
        for (int i = 0; i < 8; i++) begin
            fatal_case(12'h0, 15'h1 << dpb[i], 32'h4, 32'h1 << dpb[i]);
        end
    endtask : s_fatal

    task automatic s_next();
        clr();
        fault(12'h1, 15'h0);
        fault(12'h2, 15'h0);
        rdv(OFF_AC_FIRST, 32'h8);
        rdv(OFF_AC_NEXT, 32'h10);
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        rdv(OFF_AC_FIRST, 32'h8);
        rdv(OFF_AC_NEXT, 32'h10);
        rdv(OFF_CTRL, 32'h7);
        wr(OFF_MASK, 32'h3FFFF);
    endtask : s_next

    task automatic s_cond();
        clr();
        fault(12'h10, 15'h0);
        hold_chk(0);
        rdv(OFF_AC_FIRST, 32'h80);
        rdv(OFF_ADDR_LOG, 32'h12345678);
        wr(OFF_CTRL, 32'hF);
        for (int i = 4; i < 7; i++) begin
            clr();
            fault(12'h1 << i, 15'h0);
            hold_chk(HOLD);
            rdv(OFF_AC_FIRST, 32'h1 << (i + 3));
        end
        wr(OFF_CTRL, 32'h7);
    endtask : s_cond

    task automatic s_nonfatal();
        int nb[5] = '{0, 1, 3, 8, 9};
        logic [4:0] na[5] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01};
        for (int i = 0; i < 5; i++) begin
            clr();
            fault(12'h0, 15'h1 << nb[i]);
            @(negedge pclk);
            chk({27'h0, act}, {27'h0, na[i]});
            hold_chk(0);
            rdv(OFF_AC_FIRST, 32'h1);
            rdv(OFF_DP_FIRST, 32'h1 << nb[i]);
            chk({31'h0, irq}, 32'h1);
        end
        rdv(OFF_DB_TID, 32'hA5);
        rdv(OFF_FB_TID, 32'hA5);
    endtask : s_nonfatal

    task automatic s_repeat();
        clr();
        repeat (3) fault(12'h0, 15'h4);
        rdv(OFF_AC_FIRST, 32'h3);
        rdv(OFF_AC_NEXT, 32'h1);
        rdv(OFF_SB_TID, 32'hA5);
    endtask : s_repeat

    task automatic s_drivers();
        wr(OFF_MASK, 32'h0);
        clr();
        fault(12'h0, 15'h4000);
        hold_chk(0);
        rdv(OFF_DP_FIRST, 32'h4000);
        chk({31'h0, irq}, 32'h1);
        wr(OFF_CTRL, 32'h0);
        wr(OFF_MASK, 32'h3FFFF);
        clr();
        fault(12'h1, 15'h0);
        hold_chk(0);
        rdv(OFF_AC_FIRST, 32'h8);
        chk({31'h0, irq}, 32'h0);
        wr(OFF_CTRL, 32'h7);
    endtask : s_drivers

    task automatic s_pins();
        pin_case(0, 1'b1, 32'h4000);
        pin_case(1, 1'b1, 32'h20000);
        rdv(OFF_CMD_LOG, 32'h0000BEEF);
        pin_case(2, 1'b0, 32'h1000);
        wr(OFF_CTRL, 32'h17);
        pin_case(2, 1'b1, 32'h1000);
    endtask : s_pins

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        pwr_on_rst_n <= 1'b1;
        s_regs();
        s_fatal();
        s_next();
        s_cond();
        s_nonfatal();
        s_repeat();
        s_drivers();
        s_pins();
        finish_test();
    end

    initial begin
        #200000;
        bad_count++;
        finish_test();
    end
endmodule : tb

`default_nettype wire
